// ### logic/vad_pkg.sv
//------------------------------------------------------------
// Behaviour
//------------------------------------------------------------
// Behaviour
// - DRAM select asserts when local address lies at or below the DRAM upper limit.
// - DRAM select also asserts on a redirected slave select A match, and on a redirected B match in slave cycles.
// - Boot ROM select after global reset, on ROM access, on slave-B redirect.
// - Coprocessor select on coprocessor function code or programmed select E.
// - Subsystem bus select for region with subsystem attribute enabled.
// - Refresh grant asserts during DRAM refresh function code.
// - Upper function codes: 00 block, 01 DMA, 10 slave, 11 refresh.
// - Interface controller select on its fixed local address.
// - Block transfer input steps address counters on boundary crossing while the local count is nonzero.
// - Counters hold upper local and bus address bits over 256-byte blocks.
// - Latch address out pulse latches address; in block mode it also steps counters.
// - Cache inhibit open collector on attribute, A24 setting, mailbox or A16.
// - Local DMA activity asserts for DMA function code in mapped region.
// - Slave select A on base match with local or bus address.
// - Slave select B on bus match only; interprocessor on enabled match.
// - Low I/O selects on fixed locations, optionally via isolated data bus.
// - Pin function bit one picks alternate function, zero general I/O.
// - Pins 0..3 carry UART A tx, rx, UART B tx, rx.
// - Pin 4 is I/O read enable, pin 5 I/O write enable.
// - Select D on pin 6, E on 8, F on 9, C on 13.
// - Interrupt request goes to pin 7, 10 or 11 as chosen.
// - Pin 12 carries the shared resource select.
// - Interrupt acknowledge output on select F range when programmed.
// - Swap isolated and local data 15:8 by swap enable and direction.
package vad_pkg;
   localparam int          ADDR_W       = 24;   // Address bits 31:8
   localparam int          PIN_N        = 14;
   localparam logic [1:0]  FC_BLOCK     = 2'h0;
   localparam logic [1:0]  FC_DMA       = 2'h1;
   localparam logic [1:0]  FC_SLAVE     = 2'h2;
   localparam logic [1:0]  FC_REFRESH   = 2'h3;
   localparam logic [2:0]  FC_CPU_SPACE = 3'h7;
   localparam logic [7:0]  REGION_IO    = 8'hFF; // Top byte of I/O region
   localparam logic [7:0]  REGION_A16   = 8'hFE;
   localparam logic [7:0]  REGION_ROM   = 8'hFD;
   localparam logic [7:0]  REGION_SHR   = 8'hFC;
   localparam logic [15:0] ICTRL_ADDR   = 16'hFFFC;
   localparam logic [15:0] MAILBOX_ADDR = 16'hFFFE;
   localparam logic [3:0]  SEL_A_PAGE   = 4'h0;  // 0xFFxx0x.. select A..F
   localparam int          CNT_BITS     = 8;     // Low byte of 256-byte step
   localparam int          PIN_TXA      = 0;
   localparam int          PIN_RXA      = 1;
   localparam int          PIN_TXB      = 2;
   localparam int          PIN_RXB      = 3;
   localparam int          PIN_IO_READ_N     = 4;
   localparam int          PIN_IO_WRITE_N     = 5;
   localparam int          PIN_SELD     = 6;
   localparam int          PIN_IRQ0     = 7;
   localparam int          PIN_SELE     = 8;
   localparam int          PIN_SELF     = 9;
   localparam int          PIN_IRQ1     = 10;
   localparam int          PIN_IRQ2     = 11;
   localparam int          PIN_SHR      = 12;
   localparam int          PIN_SELC     = 13;
   localparam logic [1:0]  IRQ_PIN7     = 2'h0;
   localparam logic [1:0]  IRQ_PIN10    = 2'h1;
   localparam logic [1:0]  IRQ_PIN11    = 2'h2;
endpackage

// ### logic/vad_counter.sv
`timescale 1ns/100ps
// Upper address counter for block transfers
module vad_counter
   import vad_pkg::*;
#(
   parameter int W = ADDR_W
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Control
   input  wire logic         load,
   input  wire logic         step,
   input  wire logic [W-1:0] addr_in,
   // Count
   output logic      [W-1:0] count
);
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;

   // Load wins: a new address restarts the walk
   assign count_nxt = load ? addr_in :
                      step ? W'(count_r + 1'b1) : count_r;
   assign count = count_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   step_adds_a: assert property (@(posedge clk) disable iff (rst)
      (step && !load) |=> count_r == W'($past(count_r) + 1'b1))
      else $error("counter did not step");
endmodule

// ### logic/vad_decode.sv
`timescale 1ns/100ps
module vad_decode
   import vad_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              global_reset,
   // Local bus
   input  wire logic [ADDR_W-1:0] local_addr,
   input  wire logic              local_strobe_n,
   input  wire logic              func_code_0,
   input  wire logic              func_code_1,
   input  wire logic              func_code_2,
   input  wire logic              slave_cycle,
   // VMEbus address
   input  wire logic [ADDR_W-1:0] vme_addr,
   input  wire logic              vme_strobe_n,
   // Transfer control
   input  wire logic              block_xfer_n,
   input  wire logic              latch_addr_out,
   input  wire logic              latch_addr_in,
   input  wire logic              swap_enable_n,
   input  wire logic              data_direction,
   // Configuration
   input  wire logic [7:0]        dram_upper_limit,
   input  wire logic              redirect_sel_a,
   input  wire logic              redirect_sel_b,
   input  wire logic [15:0]       sel_a_base,
   input  wire logic [15:0]       sel_b_base,
   input  wire logic [15:0]       interproc_base,
   input  wire logic              interproc_enable,
   input  wire logic [7:0]        subsys_region_en,
   input  wire logic [7:0]        inhibit_region_en,
   input  wire logic              a24_inhibit,
   input  wire logic [7:0]        dma_region_en,
   input  wire logic [PIN_N-1:0]  pin_function,
   input  wire logic              coproc_on_sel_e,
   input  wire logic              iack_on_sel_f,
   input  wire logic              low_sel_on_idbus,
   input  wire logic [1:0]        irq_pin_choice,
   // Peripheral sources
   input  wire logic              irq_request,
   input  wire logic              uart_a_tx,
   input  wire logic              uart_b_tx,
   input  wire logic              io_read_n,
   input  wire logic              io_write_n,
   input  wire logic [PIN_N-1:0]  gpio_out,
   input  wire logic [PIN_N-1:0]  gpio_oe,
   // Shared pins
   input  wire logic [PIN_N-1:0]  shared_pin_in,
   output logic      [PIN_N-1:0]  shared_pin_out,
   output logic      [PIN_N-1:0]  shared_pin_oe,
   output logic                   uart_a_rx,
   output logic                   uart_b_rx,
   output logic      [PIN_N-1:0]  gpio_in,
   // Data swap
   input  wire logic [7:0]        id_data_in,
   input  wire logic [7:0]        ld_data_in,
   output logic      [7:0]        id_data_out,
   output logic                   id_data_oe,
   output logic      [7:0]        ld_data_out,
   output logic                   ld_data_oe,
   // Selects
   output logic                   dram_select_n,
   output logic                   boot_rom_select_n,
   output logic                   coproc_select_n,
   output logic                   subsystem_bus_select_n,
   output logic                   refresh_grant_n,
   output logic                   ctrl_select_n,
   output logic                   cache_inhibit_out,
   output logic                   cache_inhibit_oe,
   output logic                   local_dma_active_n,
   output logic                   slave_sel_a_n,
   output logic                   slave_sel_b_n,
   output logic                   interproc_sel_n,
   output logic      [1:0]        io_sel_low_n,
   output logic                   io_sel_low_idbus,
   output logic                   int_ack_cycle_n,
   output logic                   shared_res_select_n,
   // Address counters
   output logic      [ADDR_W-1:0] local_count,
   output logic      [ADDR_W-1:0] vme_count,
   output logic      [ADDR_W-1:0] latched_addr
);
   //---------------------------------------------------------
   // Decode helpers
   //---------------------------------------------------------
   // Region by top byte; region 0 is DRAM up to the limit
   function automatic logic [2:0] region_of(input logic [ADDR_W-1:0] a,
                                            input logic [7:0] lim);
      logic [2:0] r;
      r = 3'h7;
      if (a[23:16] <= lim) r = 3'h0;
      else if (a[23:16] == REGION_SHR) r = 3'h4;
      else if (a[23:16] == REGION_IO) r = 3'h5;
      else if (a[23:16] == REGION_A16) r = 3'h6;
      else if (a[23:16] == REGION_ROM) r = 3'h3;
      return r;
   endfunction

   logic        boot_r;
   logic [2:0]  loc_region;
   logic        loc_act;
   logic [1:0]  fc_hi;
   logic        fc_dma;
   logic        fc_refresh;
   logic        match_a_loc;
   logic        match_a_vme;
   logic        match_b_vme;
   logic        match_ip;
   logic        io_page;
   logic [5:0]  io_sel;
   logic        in_mailbox;
   logic        dram_nxt;
   logic        rom_nxt;
   logic        coproc_nxt;
   logic        subsys_nxt;
   logic        inhibit_nxt;
   logic        dma_nxt;
   logic        iack_nxt;
   logic        shr_nxt;
   logic        ctrl_nxt;
   logic        irq_live;
   logic [PIN_N-1:0] alt_out;
   logic [PIN_N-1:0] alt_oe;
   logic        step_cnt;
   logic        blk_r;
   logic [ADDR_W-1:0] latch_r;

   //---------------------------------------------------------
   // Function code and address decode
   //---------------------------------------------------------
   assign fc_hi       = {func_code_2, func_code_1};
   assign fc_dma      = fc_hi == FC_DMA;
   assign fc_refresh  = fc_hi == FC_REFRESH;
   assign loc_act     = !local_strobe_n;
   assign loc_region  = region_of(local_addr, dram_upper_limit);
   assign match_a_loc = loc_act && local_addr[23:8] == sel_a_base;
   assign match_a_vme = !vme_strobe_n && vme_addr[23:8] == sel_a_base;
   assign match_b_vme = !vme_strobe_n && vme_addr[23:8] == sel_b_base;
   assign match_ip    = interproc_enable && !vme_strobe_n
                        && vme_addr[23:8] == interproc_base;
   assign io_page     = loc_act && loc_region == 3'h5
                        && local_addr[15:12] == SEL_A_PAGE;
   assign in_mailbox  = local_addr[23:8] == MAILBOX_ADDR;

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_io
         assign io_sel[g] = io_page && local_addr[11:8] == 4'(g);
      end
   endgenerate

   // Redirection shares the slave select match with the local chip selects
   assign dram_nxt   = (loc_act && loc_region == 3'h0)
                       || (redirect_sel_a && match_a_vme)
                       || (redirect_sel_b && slave_cycle && match_b_vme);
   assign rom_nxt    = boot_r
                       || (loc_act && loc_region == 3'h3)
                       || (redirect_sel_b && match_b_vme);
   assign coproc_nxt = (loc_act && {func_code_2, func_code_1,
                        func_code_0} == FC_CPU_SPACE)
                       || (coproc_on_sel_e && io_sel[4]);
   assign subsys_nxt = loc_act && subsys_region_en[loc_region];
   // A24 overlay sits in the general bus window between DRAM and the fixed regions
   assign inhibit_nxt = loc_act && (inhibit_region_en[loc_region]
                        || (a24_inhibit && loc_region == 3'h7)
                        || in_mailbox || loc_region == 3'h6);
   assign dma_nxt    = fc_dma && loc_act && dma_region_en[loc_region];
   assign iack_nxt   = iack_on_sel_f && io_sel[5];
   assign shr_nxt    = loc_act && loc_region == 3'h4;
   assign ctrl_nxt   = loc_act && local_addr[23:8] == ICTRL_ADDR;

   // Boot select holds from global reset until the first local access
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         boot_r <= 1'b1;
      end else begin
         boot_r <= global_reset || (boot_r && !loc_act);
      end
   end

   // Registered selects; reset drives every select inactive except boot ROM select, which it asserts
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dram_select_n          <= 1'b1;
         boot_rom_select_n      <= 1'b0;
         coproc_select_n        <= 1'b1;
         subsystem_bus_select_n <= 1'b1;
         refresh_grant_n        <= 1'b1;
         ctrl_select_n          <= 1'b1;
         cache_inhibit_oe       <= 1'b0;
         local_dma_active_n     <= 1'b1;
         slave_sel_a_n          <= 1'b1;
         slave_sel_b_n          <= 1'b1;
         interproc_sel_n        <= 1'b1;
         io_sel_low_n           <= 2'h3;
         int_ack_cycle_n        <= 1'b1;
         shared_res_select_n    <= 1'b1;
      end else begin
         dram_select_n          <= !dram_nxt;
         boot_rom_select_n      <= !rom_nxt;
         coproc_select_n        <= !coproc_nxt;
         subsystem_bus_select_n <= !subsys_nxt;
         refresh_grant_n        <= !fc_refresh;
         ctrl_select_n          <= !ctrl_nxt;
         cache_inhibit_oe       <= inhibit_nxt;
         local_dma_active_n     <= !dma_nxt;
         slave_sel_a_n          <= !(match_a_loc || match_a_vme);
         slave_sel_b_n          <= !match_b_vme;
         interproc_sel_n        <= !match_ip;
         io_sel_low_n           <= ~io_sel[1:0];
         int_ack_cycle_n        <= !iack_nxt;
         shared_res_select_n    <= !shr_nxt;
      end
   end
   assign cache_inhibit_out = 1'b0; // Open collector: pull low only
   assign io_sel_low_idbus  = low_sel_on_idbus;

   //---------------------------------------------------------
   // Block transfer counters
   //---------------------------------------------------------
   // Step on the asserting edge of block transfer while local_count is nonzero, or a latch pulse in block mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         blk_r <= 1'b0;
      end else begin
         blk_r <= !block_xfer_n;
      end
   end
   assign step_cnt = (!block_xfer_n && !blk_r && local_count != '0)
                     || (latch_addr_out && !block_xfer_n);

   vad_counter #(.W(ADDR_W)) u_local_cnt (
      .clk     (clk),
      .rst     (rst),
      .load    (latch_addr_in),
      .step    (step_cnt),
      .addr_in (local_addr),
      .count   (local_count)
   );
   vad_counter #(.W(ADDR_W)) u_vme_cnt (
      .clk     (clk),
      .rst     (rst),
      .load    (latch_addr_out && block_xfer_n),
      .step    (step_cnt),
      .addr_in (local_addr),
      .count   (vme_count)
   );

   // Latch address out toward the bus
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_r <= '0;
      end else if (latch_addr_out) begin
         latch_r <= local_addr;
      end
   end
   assign latched_addr = latch_r;

   //---------------------------------------------------------
   // Shared pin multiplexer
   //---------------------------------------------------------
   // Requests stay off the pins while reset is held
   assign irq_live = irq_request && !rst;

   always_comb begin
      alt_out = '1;
      alt_oe  = '1;
      alt_out[PIN_TXA]  = uart_a_tx;
      alt_oe[PIN_RXA]   = 1'b0;
      alt_out[PIN_TXB]  = uart_b_tx;
      alt_oe[PIN_RXB]   = 1'b0;
      alt_out[PIN_IO_READ_N] = io_read_n;
      alt_out[PIN_IO_WRITE_N] = io_write_n;
      alt_out[PIN_SELD] = !io_sel[3];
      alt_out[PIN_SELE] = !io_sel[4];
      alt_out[PIN_SELF] = !io_sel[5];
      alt_out[PIN_SELC] = !io_sel[2];
      alt_out[PIN_SHR]  = shared_res_select_n;
      // Unchosen interrupt pins idle high so no false request shows
      alt_out[PIN_IRQ0] = !(irq_live && irq_pin_choice == IRQ_PIN7);
      alt_out[PIN_IRQ1] = !(irq_live && irq_pin_choice == IRQ_PIN10);
      alt_out[PIN_IRQ2] = !(irq_live && irq_pin_choice == IRQ_PIN11);
   end

   generate
      for (g = 0; g < PIN_N; g++) begin : g_pin
         assign shared_pin_out[g] = pin_function[g] ? alt_out[g]
                                                    : gpio_out[g];
         assign shared_pin_oe[g]  = pin_function[g] ? alt_oe[g]
                                                    : gpio_oe[g];
      end
   endgenerate
   assign gpio_in   = shared_pin_in;
   assign uart_a_rx = pin_function[PIN_RXA] ? shared_pin_in[PIN_RXA] : 1'b1;
   assign uart_b_rx = pin_function[PIN_RXB] ? shared_pin_in[PIN_RXB] : 1'b1;

   //---------------------------------------------------------
   // Data swap
   //---------------------------------------------------------
   // Direction high moves local to isolated, low the reverse
   assign id_data_out = ld_data_in;
   assign ld_data_out = id_data_in;
   assign id_data_oe  = !swap_enable_n && data_direction;
   assign ld_data_oe  = !swap_enable_n && !data_direction;

   //---------------------------------------------------------
   // Checks
   //---------------------------------------------------------
   refresh_grant_a: assert property (@(posedge clk) disable iff (rst)
      fc_refresh |=> !refresh_grant_n)
      else $error("refresh grant missing");
   dma_active_a: assert property (@(posedge clk) disable iff (rst)
      !local_dma_active_n |-> $past(fc_hi) == FC_DMA)
      else $error("dma active without dma code");
   sel_b_vme_a: assert property (@(posedge clk) disable iff (rst)
      !slave_sel_b_n |-> $past(vme_addr[23:8]) == $past(sel_b_base))
      else $error("slave select b without match");
   dram_region_a: assert property (@(posedge clk) disable iff (rst)
      (loc_act && local_addr[23:16] <= dram_upper_limit) |=> !dram_select_n)
      else $error("dram select missing");
   pin_alt_a: assert property (@(posedge clk) disable iff (rst)
      pin_function[PIN_SELD] |-> shared_pin_out[PIN_SELD] == !io_sel[3])
      else $error("select d not on pin 6");
   pin_gpio_a: assert property (@(posedge clk) disable iff (rst)
      !pin_function[PIN_IO_READ_N]
      |-> shared_pin_out[PIN_IO_READ_N] == gpio_out[PIN_IO_READ_N])
      else $error("gpio not routed");
   irq_route_a: assert property (@(posedge clk) disable iff (rst)
      (pin_function[PIN_IRQ0] && irq_live && irq_pin_choice == IRQ_PIN7)
      |-> !shared_pin_out[PIN_IRQ0])
      else $error("interrupt not on pin 7");
   swap_dir_a: assert property (@(posedge clk) disable iff (rst)
      swap_enable_n |-> !id_data_oe && !ld_data_oe)
      else $error("swap drives while disabled");
   inhibit_a16_a: assert property (@(posedge clk) disable iff (rst)
      (loc_act && loc_region == 3'h6) |=> cache_inhibit_oe)
      else $error("cache inhibit missing on a16");
   sel_a_both_a: assert property (@(posedge clk) disable iff (rst)
      (match_a_loc || match_a_vme) |=> !slave_sel_a_n)
      else $error("slave select a missing");
endmodule

// ### verif/vad_ctrl_model.sv
`timescale 1ns/100ps
// Interface controller side: function codes, swap and latch strobes
module vad_ctrl_model (
   // Clock
   input  wire logic clk,
   // Controls toward the decoder
   output logic      func_code_1,
   output logic      func_code_2,
   output logic      swap_enable_n,
   output logic      data_direction,
   output logic      block_xfer_n,
   output logic      latch_addr_out,
   output logic      latch_addr_in
);
   initial begin
      {func_code_2, func_code_1} = 2'h0;
      {swap_enable_n, data_direction} = 2'h2;
      {block_xfer_n, latch_addr_out, latch_addr_in} = 3'h4;
   end
   // Upper code bits: block, DMA, slave, refresh
   task automatic set_fc(input logic [1:0] fc);
      @(posedge clk);
      {func_code_2, func_code_1} <= fc;
   endtask
   // Swap control is held steady between transfers
   task automatic set_swap(input logic en_n, input logic dir);
      @(posedge clk);
      swap_enable_n  <= en_n;
      data_direction <= dir;
   endtask
   // Block mode settles a cycle before the latch pulse, so edge and latch steps fall on separate cycles
   task automatic pulse_out(input logic blk_n);
      @(posedge clk);
      block_xfer_n   <= blk_n;
      @(posedge clk);
      latch_addr_out <= 1'b1;
      @(posedge clk);
      latch_addr_out <= 1'b0;
   endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
   import vad_pkg::*;
;
   logic clk, rst, global_reset, local_strobe_n, vme_strobe_n, func_code_0;
   logic slave_cycle, redirect_sel_a, redirect_sel_b, interproc_enable;
   logic a24_inhibit, coproc_on_sel_e, iack_on_sel_f, low_sel_on_idbus;
   logic irq_request, uart_a_tx, uart_b_tx, io_read_n, io_write_n;
   logic [23:0] local_addr, vme_addr, local_count, vme_count, latched_addr;
   logic [15:0] sel_a_base, sel_b_base, interproc_base;
   logic [7:0]  dram_upper_limit, subsys_region_en, inhibit_region_en;
   logic [7:0]  dma_region_en, id_data_in, ld_data_in, id_data_out;
   logic [7:0]  ld_data_out;
   logic [13:0] pin_function, gpio_out, gpio_oe, shared_pin_in, gpio_in;
   logic [13:0] shared_pin_out, shared_pin_oe;
   logic [1:0]  irq_pin_choice, io_sel_low_n;
   logic uart_a_rx, uart_b_rx, id_data_oe, ld_data_oe, dram_select_n;
   logic boot_rom_select_n, coproc_select_n, subsystem_bus_select_n;
   logic refresh_grant_n, ctrl_select_n, cache_inhibit_out, cache_inhibit_oe;
   logic local_dma_active_n, slave_sel_a_n, slave_sel_b_n, interproc_sel_n;
   logic io_sel_low_idbus, int_ack_cycle_n, shared_res_select_n;
   wire logic func_code_1, func_code_2, swap_enable_n, data_direction;
   wire logic block_xfer_n, latch_addr_out, latch_addr_in;
   int num_errors, n_tests, cycles;
   int pins[4] = '{6, 8, 9, 13};
   int irqp[3] = '{7, 10, 11};

   vad_decode dut (.*);
   vad_ctrl_model pm (.*);

   always #50 clk = ~clk;
   // Whole run is well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         summarize();
      end
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Hold an address long enough for the registered selects to settle
   task automatic drv(input logic [23:0] la, input logic ls_n,
                      input logic [23:0] va, input logic vs_n);
      @(posedge clk);
      local_addr     <= la;
      local_strobe_n <= ls_n;
      vme_addr       <= va;
      vme_strobe_n   <= vs_n;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      clk = 0;
      rst = 1;
      {global_reset, func_code_0, slave_cycle, redirect_sel_a} = '0;
      {redirect_sel_b, a24_inhibit, low_sel_on_idbus, irq_request} = '0;
      {coproc_on_sel_e, iack_on_sel_f, uart_b_tx, uart_a_tx} = 4'hE;
      {local_strobe_n, vme_strobe_n, io_read_n, io_write_n} = 4'hD;
      {local_addr, vme_addr, irq_pin_choice, interproc_enable} = '0;
      {sel_a_base, sel_b_base, interproc_base} = 48'h1234_1234_5678;
      {dram_upper_limit, subsys_region_en} = 16'h1080;
      {inhibit_region_en, dma_region_en} = 16'h00FF;
      {id_data_in, ld_data_in, pin_function} = {16'hC35A, 14'h0};
      {gpio_out, gpio_oe, shared_pin_in} = {14'h1555, 14'h0F0F, 14'h0002};
      repeat (2) @(posedge clk);
      #1;
      chk({dram_select_n, boot_rom_select_n, slave_sel_a_n}, 3'h5);
      chk({ctrl_select_n, cache_inhibit_oe, shared_res_select_n}, 3'h5);
      @(posedge clk) rst <= 1'b0;
      drv(24'h0, 1, 24'h0, 1);
      chk(boot_rom_select_n, 0);
      $display("reset test done");
      drv(24'h10_0000, 0, 24'h0, 1);
      chk({dram_select_n, boot_rom_select_n}, 2'h1);
      chk(subsystem_bus_select_n, 1);
      drv(24'h11_0000, 0, 24'h0, 1);
      chk({dram_select_n, subsystem_bus_select_n}, 2'h2);
      chk(cache_inhibit_oe, 0);
      @(posedge clk) a24_inhibit <= 1'b1;
      drv(24'h11_0000, 0, 24'h0, 1);
      chk(cache_inhibit_oe, 1);
      @(posedge clk) a24_inhibit <= 1'b0;
      drv(24'hFFFC00, 0, 24'h0, 1);
      chk({ctrl_select_n, dram_select_n}, 2'h1);
      drv(24'hFFFE00, 0, 24'h0, 1);
      chk({cache_inhibit_oe, cache_inhibit_out}, 2'h2);
      drv(24'hFE0000, 0, 24'h0, 1);
      chk(cache_inhibit_oe, 1);
      drv(24'hFF0000, 0, 24'h0, 1);
      chk(io_sel_low_n, 2'h2);
      @(posedge clk) low_sel_on_idbus <= 1'b1;
      drv(24'hFF0100, 0, 24'h0, 1);
      chk({io_sel_low_n, io_sel_low_idbus}, 3'h3);
      @(posedge clk) global_reset <= 1'b1;
      drv(24'h0, 1, 24'h0, 1);
      chk(boot_rom_select_n, 0);
      @(posedge clk) global_reset <= 1'b0;
      $display("decode test done");
      drv(24'h0, 1, 24'h123400, 0);
      chk({slave_sel_a_n, slave_sel_b_n, interproc_sel_n}, 3'h1);
      drv(24'h123400, 0, 24'h0, 1);
      chk({slave_sel_a_n, slave_sel_b_n}, 2'h1);
      @(posedge clk) interproc_enable <= 1'b1;
      drv(24'h0, 1, 24'h567800, 0);
      chk(interproc_sel_n, 0);
      @(posedge clk) interproc_enable <= 1'b0;
      drv(24'h0, 1, 24'h567800, 0);
      chk(interproc_sel_n, 1);
      @(posedge clk) {redirect_sel_a, redirect_sel_b} <= 2'h3;
      drv(24'h0, 1, 24'h123400, 0);
      chk({dram_select_n, boot_rom_select_n}, 2'h0);
      @(posedge clk) {redirect_sel_a, redirect_sel_b} <= 2'h0;
      $display("slave test done");
      @(posedge clk) func_code_0 <= 1'b1;
      for (int f = 0; f < 4; f++) begin
         pm.set_fc(2'(f));
         drv(24'h0, 0, 24'h0, 1);
         chk(refresh_grant_n, f != 3);
         chk(local_dma_active_n, f != 1);
         chk(coproc_select_n, f != 3);
      end
      pm.set_fc(2'h2);
      func_code_0 <= 1'b0;
      $display("function code test done");
      @(posedge clk) pin_function <= '1;
      for (int g = 0; g < 4; g++) begin
         drv({12'hFF0, 4'(g == 3 ? 2 : g + 3), 8'h0}, 0, 24'h0, 1);
         chk({shared_pin_out[pins[g]], shared_pin_oe[pins[g]]}, 2'h1);
         if (g == 1) chk(coproc_select_n, 0);
         if (g == 2) chk(int_ack_cycle_n, 0);
      end
      chk({shared_pin_out[5:0], uart_a_rx, uart_b_rx}, 8'hBA);
      chk(shared_pin_oe[3:0], 4'h5);
      @(posedge clk) irq_request <= 1'b1;
      for (int c = 0; c < 3; c++) begin
         @(posedge clk) irq_pin_choice <= 2'(c);
         drv(24'h0, 1, 24'h0, 1);
         chk(shared_pin_out[irqp[c]], 0);
         chk(shared_pin_out[irqp[(c + 1) % 3]], 1);
         chk(shared_pin_out[irqp[(c + 2) % 3]], 1);
      end
      drv(24'hFC0000, 0, 24'h0, 1);
      chk({shared_pin_out[12], shared_res_select_n}, 2'h0);
      @(posedge clk) pin_function <= '0;
      drv(24'h0, 1, 24'h0, 1);
      chk(shared_pin_out, gpio_out);
      chk(gpio_in, shared_pin_in);
      chk(shared_pin_oe, gpio_oe);
      $display("pin test done");
      for (int d = 0; d < 2; d++) begin
         pm.set_swap(0, d[0]);
         @(posedge clk);
         #1;
         chk({id_data_oe, ld_data_oe}, d[0] ? 2'h2 : 2'h1);
         chk(d[0] ? id_data_out : ld_data_out, d[0] ? 8'h5A : 8'hC3);
      end
      pm.set_swap(1, 0);
      @(posedge clk);
      #1;
      chk({id_data_oe, ld_data_oe}, 2'h0);
      $display("swap test done");
      drv(24'hABCD00, 1, 24'h0, 1);
      pm.pulse_out(1);
      @(posedge clk);
      #1;
      chk(latched_addr, 24'hABCD00);
      pm.pulse_out(0);
      @(posedge clk);
      #1;
      chk(vme_count, 24'hABCD01);
      chk(local_count, 24'h000001);
      $display("counter test done");
      summarize();
   end
endmodule
